// ---- hw/euc_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the encoder counter
`ifndef EUC_DEFS_SVH
`define EUC_DEFS_SVH
`define EUC_ADDR_W 4
`define EUC_OFS_COUNT 4'h0
`define EUC_OFS_CMP_A 4'h1
`define EUC_OFS_CMP_B 4'h2
`define EUC_OFS_CC_A 4'h3
`define EUC_OFS_CC_B 4'h4
`define EUC_OFS_MODE 4'h5
`define EUC_OFS_CTRL 4'h6
`define EUC_OFS_CCCTL 4'h7
`define EUC_OFS_EDGE 4'h8
`define EUC_OFS_PRESC 4'h9
`define EUC_OFS_STATUS 4'ha
// Unit mode register fields
`define EUC_MODE_VARIANT 0
`define EUC_MODE_POL 2
`define EUC_MODE_TOE 3
`define EUC_MODE_CMD 7
`define EUC_MODE_SCHEME_LO 4
// Control register fields
`define EUC_CTRL_CLR0 0
`define EUC_CTRL_CLR1 1
`define EUC_CTRL_ENMD 2
`define EUC_CTRL_RUN 6
// Capture/compare control fields (1 = compare)
`define EUC_CCCTL_A 0
`define EUC_CCCTL_B 1
`define EUC_RESET_16 16'h0000
`define EUC_RESET_8 8'h00
// Timing: fastest count clock allowed, in MHz, against a 40 MHz system clock
`define EUC_SYS_MHZ 40
`define EUC_MAX_CNT_MHZ 10
`define EUC_MIN_DIV_CYC ((`EUC_SYS_MHZ + `EUC_MAX_CNT_MHZ - 1) / `EUC_MAX_CNT_MHZ)
`endif

// ---- hw/euc_pkg.sv ----
// Types shared by the encoder counter files
package euc_pkg;
   typedef logic [15:0] euc_word_t;
   typedef enum logic [1:0] {
      EUC_SCH_PULSE_DIR = 2'b00,
      EUC_SCH_UP_DOWN = 2'b01,
      EUC_SCH_QUAD_X1 = 2'b11,
      EUC_SCH_QUAD_X4 = 2'b10
   } euc_scheme_e;
   typedef enum logic [1:0] {
      EUC_EDGE_FALL = 2'b00,
      EUC_EDGE_RISE = 2'b01,
      EUC_EDGE_BOTH = 2'b10,
      EUC_EDGE_NONE = 2'b11
   } euc_edge_e;
endpackage

// ---- hw/euc_sync.sv ----
// Two-flop synchroniser and edge detector for the encoder counter pins
`timescale 1ns/1ps
module euc_sync (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Pin in, clean level and edges out
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   import euc_pkg::*;
   typedef struct packed {
      logic meta;
      logic stable;
      logic prev;
   } euc_sync_s;
   euc_sync_s st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.meta = i_pin;
      st_d.stable = st_q.meta;
      st_d.prev = st_q.stable;
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   // Edges come from the second and third stages only, one cycle each
   assign o_level = st_q.stable;
   assign o_rise = st_q.stable & ~st_q.prev;
   assign o_fall = ~st_q.stable & st_q.prev;
endmodule

// ---- hw/euc_counter.sv ----
// Sixteen-bit up/down encoder counter with compare, capture and PWM output
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "euc_defs.svh"
// Contract
// (RULE1) Counter value resets to zero.
// (RULE2) Software writes the counter only while counting is stopped.
// (RULE3) Software never selects timer mode together with variant B.
// (RULE4) Timer mode counts on system clock divided by 2 to 128.
// (RULE5) Software keeps the count clock at ten megahertz or below.
// (RULE6) While running: timer counts up, up/down mode follows the encoder.
// (RULE7) Scheme 1 counts pulses, direction input sets up or down.
// (RULE8) Scheme 2 counts up on one input, down on the other.
// (RULE9) Scheme 3 counts once per cycle with phase-derived direction.
// (RULE10) Scheme 4 counts on every edge of both inputs.
// (RULE11) Timer mode clears on compare A only when clear-enable is set.
// (RULE12) Variant A clear condition: external, compare-up, either, or none.
// (RULE13) Variant B clears on A match up, B match down.
// (RULE14) Timer mode and variant A raise compare-A event on every match.
// (RULE15) Variant B raises compare-A event only on down-count matches.
// (RULE16) Software leaves compare A alone while running.
// (RULE17) Direction input use disables capture through capture pin A.
// (RULE18) External clear in variant A disables capture through pin B.
// (RULE19) Valid capture edge latches the count into its capture register.
// (RULE20) Software never reads the counter twice back to back.
// (RULE21) No identical rewrites of counter, capture and status registers.
// (RULE22) Timer mode drives a 16-bit PWM on the timer output.
// (RULE23) Up/down mode holds timer output at the inactive level.
// (RULE24) Capture events pulse their event on each selected edge.
// (RULE25) Pins are synchronised so each event lasts one cycle.
// (RULE26) Clear beats a coinciding count event.
module euc_counter (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Register port
   input wire logic [`EUC_ADDR_W-1:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Encoder and capture pins
   input wire logic i_encoder_pulse_in,
   input wire logic i_encoder_dir_in,
   input wire logic i_ext_clear_pin,
   // Timer output pin
   output logic o_timer_out_pin,
   // Event pulses
   output logic o_compare_a_irq,
   output logic o_compare_b_irq,
   output logic o_capcomp_a_irq,
   output logic o_capcomp_b_irq
);
   import euc_pkg::*;

   typedef struct packed {
      euc_pkg::euc_word_t count;
      euc_pkg::euc_word_t cmp_a;
      euc_pkg::euc_word_t cmp_b;
      euc_pkg::euc_word_t cc_a;
      euc_pkg::euc_word_t cc_b;
      logic [7:0] mode;
      logic [7:0] ctrl;
      logic [7:0] ccctl;
      logic [7:0] edge_sel;
      logic [2:0] presc;
      logic [6:0] div;
      logic [7:0] status;
      logic dir_down;
      logic pwm;
      logic [15:0] rdata;
      logic ev_cmp_a;
      logic ev_cmp_b;
      logic ev_cc_a;
      logic ev_cc_b;
   } euc_state_s;

   euc_state_s st_q, st_d;

   logic pa_lvl, pa_r, pa_f, pb_lvl, pb_r, pb_f, cl_lvl, cl_r, cl_f;

   // Synchronised pins (see RULE25)
   euc_sync u_sync_a (.i_clock(i_clock), .i_srst(i_srst), .i_pin(i_encoder_pulse_in),
      .o_level(pa_lvl), .o_rise(pa_r), .o_fall(pa_f));
   euc_sync u_sync_b (.i_clock(i_clock), .i_srst(i_srst), .i_pin(i_encoder_dir_in),
      .o_level(pb_lvl), .o_rise(pb_r), .o_fall(pb_f));
   euc_sync u_sync_c (.i_clock(i_clock), .i_srst(i_srst), .i_pin(i_ext_clear_pin),
      .o_level(cl_lvl), .o_rise(cl_r), .o_fall(cl_f));

   function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
      unique case (euc_edge_e'(sel))
         EUC_EDGE_FALL: edge_hit = f;
         EUC_EDGE_RISE: edge_hit = r;
         EUC_EDGE_BOTH: edge_hit = r | f;
         EUC_EDGE_NONE: edge_hit = 1'b0;
      endcase
   endfunction

   logic run, udc, var_b, presc_tick, cnt_ev, cnt_dn, clr, match_a, match_b;
   logic ext_clr_used, cap_a, cap_b;
   logic [6:0] div_mask;
   euc_scheme_e scheme;

   always_comb begin
      run = st_q.ctrl[`EUC_CTRL_RUN];
      udc = st_q.mode[`EUC_MODE_CMD];
      var_b = st_q.mode[`EUC_MODE_VARIANT];
      scheme = euc_scheme_e'(st_q.mode[`EUC_MODE_SCHEME_LO +: 2]);
      // Divide by 2^(presc+1); code 7 is treated as 128 (see RULE4)
      div_mask = 7'h7f >> (3'h6 - ((st_q.presc == 3'h7) ? 3'h6 : st_q.presc));
      presc_tick = ((st_q.div & div_mask) == div_mask);
      cnt_ev = 1'b0;
      cnt_dn = 1'b0;
      if (!udc) begin
         cnt_ev = presc_tick; // see RULE6
      end else begin
         unique case (scheme)
            EUC_SCH_PULSE_DIR: begin
               cnt_ev = pa_r; // see RULE7
               cnt_dn = pb_lvl;
            end
            EUC_SCH_UP_DOWN: begin
               cnt_ev = pa_r ^ pb_r; // see RULE8
               cnt_dn = pb_r;
            end
            EUC_SCH_QUAD_X1: begin
               cnt_ev = pa_r; // see RULE9
               cnt_dn = pb_lvl;
            end
            EUC_SCH_QUAD_X4: begin
               cnt_ev = pa_r | pa_f | pb_r | pb_f; // see RULE10
               cnt_dn = ((pa_r | pa_f) & (pa_lvl == pb_lvl)) |
                        ((pb_r | pb_f) & (pa_lvl != pb_lvl));
            end
         endcase
      end
      cnt_ev = cnt_ev & run;
      // Direction used for compare decisions is that of the last count
      match_a = (st_q.count == st_q.cmp_a);
      match_b = (st_q.count == st_q.cmp_b);
      ext_clr_used = udc && !var_b && !st_q.ctrl[`EUC_CTRL_CLR1] ? !st_q.ctrl[`EUC_CTRL_CLR0]
         : (udc && !var_b && st_q.ctrl[`EUC_CTRL_CLR1] && !st_q.ctrl[`EUC_CTRL_CLR0]);
      clr = 1'b0;
      if (!udc) begin
         clr = st_q.ctrl[`EUC_CTRL_ENMD] & match_a & presc_tick; // see RULE11
      end else if (var_b) begin
         clr = (match_a & !st_q.dir_down) | (match_b & st_q.dir_down); // see RULE13
      end else begin
         unique case ({st_q.ctrl[`EUC_CTRL_CLR1], st_q.ctrl[`EUC_CTRL_CLR0]})
            2'b00: clr = cl_r; // see RULE12
            2'b01: clr = match_a & !st_q.dir_down;
            2'b10: clr = cl_r | (match_a & !st_q.dir_down);
            2'b11: clr = 1'b0;
         endcase
      end
      clr = clr & run;
      // Shared pins lose their capture role when the counter uses them
      cap_a = run && !udc && !st_q.ccctl[`EUC_CCCTL_A] &&
         edge_hit(st_q.edge_sel[1:0], pb_r, pb_f); // see RULE17
      cap_b = run && !ext_clr_used && !st_q.ccctl[`EUC_CCCTL_B] &&
         edge_hit(st_q.edge_sel[3:2], cl_r, cl_f); // see RULE18
   end

   always_comb begin
      st_d = st_q;
      st_d.div = run ? st_q.div + 7'h01 : 7'h00;
      if (cnt_ev) begin
         st_d.dir_down = udc & cnt_dn;
      end
      if (clr) begin
         st_d.count = `EUC_RESET_16; // see RULE26
      end else if (cnt_ev) begin
         st_d.count = (udc && cnt_dn) ? st_q.count - 16'h0001 : st_q.count + 16'h0001;
      end
      st_d.ev_cmp_a = match_a && (run && cnt_ev || clr) &&
         (!udc || !var_b || st_q.dir_down); // see RULE14 see RULE15
      st_d.ev_cmp_b = match_b && (run && cnt_ev || clr) && (!udc || !var_b || st_q.dir_down);
      st_d.ev_cc_a = cap_a | (st_q.ccctl[`EUC_CCCTL_A] & run & cnt_ev &
         (st_q.count == st_q.cc_a)); // see RULE24
      st_d.ev_cc_b = cap_b | (st_q.ccctl[`EUC_CCCTL_B] & run & cnt_ev &
         (st_q.count == st_q.cc_b));
      if (cap_a) begin
         st_d.cc_a = st_q.count; // see RULE19
      end
      if (cap_b) begin
         st_d.cc_b = st_q.count;
      end
      // PWM: active from clear or zero count until compare B, inactive until the next clear or zero count
      if (!udc && run) begin
         if (clr || st_q.count == 16'h0000) begin
            st_d.pwm = 1'b1; // see RULE22
         end else if (match_b) begin
            st_d.pwm = 1'b0;
         end
      end else begin
         st_d.pwm = 1'b0;
      end
      // Status: bit0 running, bit1 last direction down
      st_d.status = {6'h00, st_q.dir_down, run};
      if (i_wr) begin
         unique case (i_addr)
            `EUC_OFS_COUNT: st_d.count = i_wdata; // see RULE2
            `EUC_OFS_CMP_A: st_d.cmp_a = i_wdata;
            `EUC_OFS_CMP_B: st_d.cmp_b = i_wdata;
            `EUC_OFS_CC_A: st_d.cc_a = i_wdata;
            `EUC_OFS_CC_B: st_d.cc_b = i_wdata;
            `EUC_OFS_MODE: st_d.mode = i_wdata[7:0];
            `EUC_OFS_CTRL: st_d.ctrl = i_wdata[7:0];
            `EUC_OFS_CCCTL: st_d.ccctl = i_wdata[7:0];
            `EUC_OFS_EDGE: st_d.edge_sel = i_wdata[7:0];
            `EUC_OFS_PRESC: st_d.presc = i_wdata[2:0];
            default: ;
         endcase
      end
      st_d.rdata = 16'h0000;
      if (i_rd) begin
         unique case (i_addr)
            `EUC_OFS_COUNT: st_d.rdata = st_q.count;
            `EUC_OFS_CMP_A: st_d.rdata = st_q.cmp_a;
            `EUC_OFS_CMP_B: st_d.rdata = st_q.cmp_b;
            `EUC_OFS_CC_A: st_d.rdata = st_q.cc_a;
            `EUC_OFS_CC_B: st_d.rdata = st_q.cc_b;
            `EUC_OFS_MODE: st_d.rdata = {8'h00, st_q.mode};
            `EUC_OFS_CTRL: st_d.rdata = {8'h00, st_q.ctrl};
            `EUC_OFS_CCCTL: st_d.rdata = {8'h00, st_q.ccctl};
            `EUC_OFS_EDGE: st_d.rdata = {8'h00, st_q.edge_sel};
            `EUC_OFS_PRESC: st_d.rdata = {13'h0000, st_q.presc};
            `EUC_OFS_STATUS: st_d.rdata = {8'h00, st_q.status};
            default: st_d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         st_q <= '0; // see RULE1
      end else begin
         st_q <= st_d;
      end
   end

   assign o_rdata = st_q.rdata;
   // Output stays inactive unless timer mode with output enabled (see RULE23)
   assign o_timer_out_pin = ((st_q.pwm & st_q.mode[`EUC_MODE_TOE] & ~udc) ^
      st_q.mode[`EUC_MODE_POL]);
   assign o_compare_a_irq = st_q.ev_cmp_a;
   assign o_compare_b_irq = st_q.ev_cmp_b;
   assign o_capcomp_a_irq = st_q.ev_cc_a;
   assign o_capcomp_b_irq = st_q.ev_cc_b;
endmodule

// ---- bench/euc_enc.sv ----
// Behavioural encoder and clear-line driver facing the counter pins
`timescale 1ns/1ps
module euc_enc (
   // Clock
   input wire logic i_clock,
   // Pins: [2] clear, [1] phase B or down, [0] phase A or up
   output logic [2:0] o_pins
);
   initial o_pins = 3'h0;
   // Each level holds four cycles, one more than the synchroniser needs
   task automatic hold();
      repeat (4) @(posedge i_clock);
   endtask
   // One quadrature edge; phase A leads on the way up
   task automatic quad(input logic up);
      @(posedge i_clock);
      if ((o_pins[0] == o_pins[1]) == up)
         o_pins[0] <= ~o_pins[0];
      else
         o_pins[1] <= ~o_pins[1];
      hold();
   endtask
   // A whole pulse on one line, low again at the end
   task automatic pulse(input int pin);
      @(posedge i_clock);
      o_pins[pin] <= 1'b1;
      hold();
      o_pins[pin] <= 1'b0;
      hold();
   endtask
endmodule

// ---- bench/euc_counter_chk.sv ----
// Port-level assertions for the encoder counter
`timescale 1ns/1ps
`include "euc_defs.svh"
module euc_counter_chk (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Register writes and read data
   input wire logic [`EUC_ADDR_W-1:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic [15:0] o_rdata,
   // Output pin and events
   input wire logic o_timer_out_pin,
   input wire logic o_compare_a_irq,
   input wire logic o_compare_b_irq,
   input wire logic o_capcomp_a_irq,
   input wire logic o_capcomp_b_irq
);
   logic [7:0] mode_q, ctrl_q, cc_q;
   logic cmp_any, cap_any, run;
   assign cmp_any = o_compare_a_irq | o_compare_b_irq;
   assign cap_any = o_capcomp_a_irq | o_capcomp_b_irq;
   assign run = ctrl_q[`EUC_CTRL_RUN];
   // Shadows come from bus writes, since only the ports are visible
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         mode_q <= 8'h00;
         ctrl_q <= 8'h00;
         cc_q <= 8'h00;
      end else if (i_wr) begin
         if (i_addr == `EUC_OFS_MODE) mode_q <= i_wdata[7:0];
         if (i_addr == `EUC_OFS_CTRL) ctrl_q <= i_wdata[7:0];
         if (i_addr == `EUC_OFS_CCCTL) cc_q <= i_wdata[7:0];
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   AST_RST_IDLE: assert property ($fell(i_srst) |-> o_rdata == 16'h0000 && !cmp_any)
      else $error("outputs busy after reset");
   AST_STOP_NO_CMP: assert property (!run [*6] |-> !cmp_any)
      else $error("compare event while stopped");
   AST_STOP_NO_CAP: assert property (!run [*6] |-> !cap_any)
      else $error("capture event while stopped");
   AST_CMP_PULSE: assert property (o_compare_a_irq |=> !o_compare_a_irq)
      else $error("compare event longer than a cycle");
   AST_CAP_PULSE: assert property ($rose(o_capcomp_b_irq) |=> $fell(o_capcomp_b_irq))
      else $error("capture event longer than a cycle");
   AST_UD_OUT: assert property (mode_q[7] && $past(mode_q) == mode_q &&
      $past(mode_q, 2) == mode_q |-> o_timer_out_pin == mode_q[`EUC_MODE_POL])
      else $error("timer output active in up/down mode");
   AST_CAPA_OFF: assert property (mode_q[7] && !cc_q[0] |-> !o_capcomp_a_irq)
      else $error("capture A in up/down mode");
   AST_CAPB_OFF: assert property (mode_q[7] && !mode_q[0] && !ctrl_q[0] &&
      !cc_q[1] |-> !o_capcomp_b_irq)
      else $error("capture B while clear pin used");
   cover property (o_compare_a_irq);
   cover property (o_capcomp_b_irq);
   cover property (mode_q[7] && run);
endmodule

// ---- bench/test_euc_counter.sv ----
// Self-checking bench for the encoder counter
`timescale 1ns/1ps
`include "euc_defs.svh"
module test_euc_counter;
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [`EUC_ADDR_W-1:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic [15:0] o_rdata, n;
   logic [2:0] pins;
   logic tout, cmpa, cmpb, cca, ccb;
   int num_errors = 0, cmp_count = 0, cmpa_n = 0, ccb_n = 0, cmpb_n = 0, k;
   always @(negedge i_clock) if (cmpb === 1'b1) cmpb_n++;
   always #12.5 i_clock = ~i_clock;
   always @(negedge i_clock) if (cmpa === 1'b1) cmpa_n++;
   always @(negedge i_clock) if (ccb === 1'b1) ccb_n++;
   euc_enc euc_enc_inst (.i_clock, .o_pins(pins));
   euc_counter euc_counter_inst (.i_clock, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .i_encoder_pulse_in(pins[0]), .i_encoder_dir_in(pins[1]),
      .i_ext_clear_pin(pins[2]), .o_timer_out_pin(tout), .o_compare_a_irq(cmpa),
      .o_compare_b_irq(cmpb), .o_capcomp_a_irq(cca), .o_capcomp_b_irq(ccb));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 check(o_rdata, exp);
   endtask
   // Cycles between two compare A events, capped so a silent design ends
   task automatic gap(output logic [15:0] c);
      int w;
      w = 0;
      while (cmpa !== 1'b1 && w < 600) begin
         @(posedge i_clock);
         #1 w++;
      end
      c = 16'h0000;
      do begin
         @(posedge i_clock);
         #1 c++;
      end while (cmpa !== 1'b1 && c < 16'h0258);
   endtask
   // Count may only be written while stopped, so stop first
   task automatic ud_run(input logic [15:0] mode);
      wr(`EUC_OFS_CTRL, 16'h0003);
      wr(`EUC_OFS_COUNT, 16'h0000);
      wr(`EUC_OFS_MODE, mode);
      wr(`EUC_OFS_CTRL, 16'h0043);
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge i_clock);
      i_srst <= 1'b0;
      rd(`EUC_OFS_COUNT, 16'h0000);
      rd(`EUC_OFS_CMP_A, 16'h0000);
      wr(`EUC_OFS_CMP_B, 16'h8001);
      rd(`EUC_OFS_CMP_B, 16'h8001);
      rd(4'hf, 16'h0000);
      $display("test registers done");
      // Compare A of 3 with clear enabled gives four ticks per period
      wr(`EUC_OFS_CMP_A, 16'h0003);
      for (int p = 1; p < 3; p++) begin
         wr(`EUC_OFS_PRESC, 16'(p));
         wr(`EUC_OFS_CTRL, 16'h0044);
         gap(n);
         check(n, 16'(4 << (p + 1)));
         wr(`EUC_OFS_CTRL, 16'h0000);
      end
      $display("test timer done");
      wr(`EUC_OFS_EDGE, 16'h0007);
      ud_run(16'h0090);
      euc_enc_inst.pulse(0);
      euc_enc_inst.pulse(0);
      euc_enc_inst.pulse(1);
      rd(`EUC_OFS_COUNT, 16'h0001);
      ud_run(16'h00a0);
      repeat (5) euc_enc_inst.quad(1'b1);
      repeat (2) euc_enc_inst.quad(1'b0);
      rd(`EUC_OFS_COUNT, 16'h0003);
      ud_run(16'h00b0);
      repeat (8) euc_enc_inst.quad(1'b1);
      repeat (4) euc_enc_inst.quad(1'b0);
      rd(`EUC_OFS_COUNT, 16'h0001);
      $display("test up/down done");
      euc_enc_inst.pulse(2);
      check(16'(ccb_n), 16'h0001);
      rd(`EUC_OFS_CC_B, 16'h0001);
      wr(`EUC_OFS_CTRL, 16'h0040);
      euc_enc_inst.pulse(2);
      rd(`EUC_OFS_COUNT, 16'h0000);
      check(16'(ccb_n), 16'h0001);
      wr(`EUC_OFS_CTRL, 16'h0000);
      wr(`EUC_OFS_CMP_A, 16'h0002);
      k = cmpa_n;
      ud_run(16'h00a1);
      repeat (3) euc_enc_inst.quad(1'b1);
      // Third step lands after the clear at the compare A match
      rd(`EUC_OFS_COUNT, 16'h0001);
      check(16'(cmpa_n - k), 16'h0000);
      check(16'(cmpb_n), 16'h0000);
      // Output enable set too: up/down mode must still hold the inactive level
      ud_run(16'h008c);
      euc_enc_inst.hold();
      check(16'(tout), 16'h0001);
      $display("test clear and capture done");
      complete_run();
   end
   initial begin
      #300us;
      num_errors++;
      complete_run();
   end
endmodule
bind euc_counter euc_counter_chk euc_counter_chk_inst (.i_clock, .i_srst, .i_addr,
   .i_wdata, .i_wr, .o_rdata, .o_timer_out_pin, .o_compare_a_irq, .o_compare_b_irq,
   .o_capcomp_a_irq, .o_capcomp_b_irq);
